//--- common/diag_regs.svh
// Constants for the diagnostic flag and serial status block.
// Assumes a 50 MHz system clock; all times are minimum (round up).
//
// Notes on behaviour
// R1 - medium temp sets in normal power, battery ok
// R2 - medium temp clears cool, or read low-power
// R3 - medium temp flag triggers no action
// R4 - high temp sets in normal power, battery ok
// R5 - high temp clears on enable falling edge
// R6 - high temp keeps transmitter disabled
// R7 - clamp flag after long enable-low guardian-high
// R8 - clamp clears on release; disables transmitter
// R9 - bus error on data mismatch while transmitting
// R10 - bus error clears on match or disable
// R11 - battery undervoltage follows monitor, wake clears
// R12 - core undervoltage filtered set and recovery
// R13 - interface undervoltage filtered set, instant recovery
// R14 - error flag is OR of S4..S10
// R15 - host shifts status with mode-select clock
// R16 - readout gated by supply undervoltage flags
// R17 - idle after read clears S4..S10 if flag clear
// R18 - error output low for set status bit
// R19 - S0, S1 mirror local, remote wake source
// R20 - S2 always one, S11 S12 always zero
// R21 - S3..S10 sticky records in fixed order
// R22 - wake flag clears on mode entry, undervoltage
// R23 - power-on flag sets at supply, clears normal
// R24 - wake sources set in low power, cleared entry
// R25 - readout starts at S0, ends at S12
// R26 - sticky bits set on flag rising edge
`ifndef DIAG_REGS_SVH
`define DIAG_REGS_SVH

// -----------------------------------------------------------------
// status word layout
// -----------------------------------------------------------------
`define STATUS_W        13
`define ST_LOCAL_WAKE   0
`define ST_REMOTE_WAKE  1
`define ST_FIXED_SET    2
`define ST_STICKY_LO    3
`define ST_ERR_LO       4
`define ST_ERR_HI       10
`define ST_SPARE_LO     11
`define ST_SPARE_HI     12
`define STICKY_N        8

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define SYS_CLK_MHZ      50
`define NS_TO_CYC(ns)    ((((ns) * `SYS_CLK_MHZ) + 999) / 1000)
`define CLAMP_DET_NS     2000
`define CLAMP_DET_CYC    `NS_TO_CYC(`CLAMP_DET_NS)
`define CORE_UV_DET_NS   10000
`define CORE_UV_DET_CYC  `NS_TO_CYC(`CORE_UV_DET_NS)
`define CORE_UV_REC_NS   10000
`define CORE_UV_REC_CYC  `NS_TO_CYC(`CORE_UV_REC_NS)
`define IFACE_UV_DET_NS  10000
`define IFACE_UV_DET_CYC `NS_TO_CYC(`IFACE_UV_DET_NS)
`define READ_IDLE_NS     200000
`define READ_IDLE_CYC    `NS_TO_CYC(`READ_IDLE_NS)

`endif

//--- common/diag_pkg.sv
// Types shared by the diagnostic block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package diag_pkg;

  // inputs from pins and analog monitors, all asynchronous
  typedef struct packed {
    logic shift_clk;
    logic transmit_enable_low;
    logic guardian_enable;
    logic txd;
    logic rx_data;
    logic valid_element;
    logic temp_above_medium;
    logic temp_above_high;
    logic batt_in_range;
    logic batt_low;
    logic core_low;
    logic iface_low;
    logic iface_is_5v;
    logic supply_ok;
  } pin_in_t;

  // mode controller outputs, same clock
  typedef struct packed {
    logic in_normal_power;
    logic in_low_power;
    logic enter_normal;
    logic enter_low_power;
    logic local_wake_event;
    logic remote_wake_event;
    logic wake_request;
  } mode_in_t;

  // bit i maps to status bit S3+i
  typedef struct packed {
    logic iface_uv;
    logic core_uv;
    logic batt_uv;
    logic clamped;
    logic temp_medium;
    logic temp_high;
    logic bus_error;
    logic power_on;
  } flags_t;

  typedef enum logic {RD_IDLE, RD_SHIFT} readout_state_t;

endpackage

//--- hw/uv_filter.sv
// Persistence filter for an undervoltage monitor level.
// Assumes a synchronised input on the same clock.
`timescale 1ns/100ps
`default_nettype none
module uv_filter #(
  parameter int unsigned DET_CYC = 1,
  parameter int unsigned REC_CYC = 1
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic low_in,
  output logic      set_pulse,
  output logic      clr_pulse
);
  localparam int unsigned MAXC = (DET_CYC > REC_CYC) ? DET_CYC : REC_CYC;
  localparam int unsigned CW   = $clog2(MAXC + 1);

  logic [CW-1:0] cnt_r;
  logic          level_r;

  // counts while input disagrees with filtered level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r   <= '0;
      level_r <= 1'b0;
    end else if (low_in == level_r) begin
      cnt_r <= '0;
    end else if (!level_r && cnt_r >= CW'(DET_CYC)) begin
      level_r <= 1'b1;
      cnt_r   <= '0;
    end else if (level_r && cnt_r >= CW'(REC_CYC)) begin
      level_r <= 1'b0;
      cnt_r   <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign set_pulse = (low_in && !level_r && cnt_r >= CW'(DET_CYC));
  assign clr_pulse = (!low_in && level_r && cnt_r >= CW'(REC_CYC));
endmodule
`default_nettype wire

//--- hw/diag_flags_serial_status.sv
// Diagnostic flags, sticky status word and serial readout.
// Assumes pin inputs are asynchronous and the mode controller
// shares clk_sys; the host clocks the readout on shift_clk.
`include "diag_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module diag_flags_serial_status #(
  parameter int unsigned CLAMP_CYC    = `CLAMP_DET_CYC,
  parameter int unsigned CORE_DET_CYC = `CORE_UV_DET_CYC,
  parameter int unsigned CORE_REC_CYC = `CORE_UV_REC_CYC,
  parameter int unsigned IO_DET_CYC   = `IFACE_UV_DET_CYC,
  parameter int unsigned IDLE_CYC     = `READ_IDLE_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire diag_pkg::pin_in_t pins,
  input  wire diag_pkg::mode_in_t mode,
  output logic                   error_out_low,
  output logic                   transmitter_disable,
  output logic                   error_flag,
  output logic                   wake_flag,
  output diag_pkg::flags_t       flags,
  output logic [`STATUS_W-1:0]   status_word
);

  localparam int unsigned PW    = $bits(diag_pkg::pin_in_t);
  localparam int unsigned CLW   = $clog2(CLAMP_CYC + 2);
  localparam int unsigned IDW   = $clog2(IDLE_CYC + 2);
  localparam int unsigned IXW   = $clog2(`STATUS_W + 1);

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  logic [PW-1:0]     meta_r;
  logic [PW-1:0]     sync_r;
  diag_pkg::pin_in_t pin_s;

  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= pins[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  assign pin_s = diag_pkg::pin_in_t'(sync_r);

  // -----------------------------------------------------------------
  // edge history
  // -----------------------------------------------------------------
  logic transmit_enable_low_prev_r;
  logic clk_prev_r;
  logic supply_prev_r;
  logic batt_low_prev_r;

  // matches the synchroniser's reset level, so no false fall after reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      transmit_enable_low_prev_r     <= 1'b0;
      clk_prev_r      <= 1'b0;
      supply_prev_r   <= 1'b0;
      batt_low_prev_r <= 1'b0;
    end else begin
      transmit_enable_low_prev_r     <= pin_s.transmit_enable_low;
      clk_prev_r      <= pin_s.shift_clk;
      supply_prev_r   <= pin_s.supply_ok;
      batt_low_prev_r <= pin_s.batt_low;
    end
  end

  logic transmit_enable_low_fall;
  logic clk_rise;
  logic clk_any;
  logic supply_rise;
  logic batt_low_rise;
  logic batt_recover;

  assign transmit_enable_low_fall     = transmit_enable_low_prev_r && !pin_s.transmit_enable_low;
  assign clk_rise      = pin_s.shift_clk && !clk_prev_r;
  assign clk_any       = pin_s.shift_clk != clk_prev_r;
  assign supply_rise   = pin_s.supply_ok && !supply_prev_r;
  assign batt_low_rise = pin_s.batt_low && !batt_low_prev_r;
  assign batt_recover  = !pin_s.batt_low && batt_low_prev_r;

  // -----------------------------------------------------------------
  // common qualifiers
  // -----------------------------------------------------------------
  diag_pkg::flags_t flags_r;
  logic             normal_ok;
  logic             low_ok;
  logic             tx_request;
  logic             tx_blocked;
  logic             read_clear;

  assign normal_ok  = mode.in_normal_power && pin_s.batt_in_range;
  assign low_ok     = mode.in_low_power && pin_s.batt_in_range;
  assign tx_request = !pin_s.transmit_enable_low && pin_s.guardian_enable;
  assign tx_blocked = flags_r.temp_high || flags_r.clamped;

  // -----------------------------------------------------------------
  // wake source flags and wake flag
  // -----------------------------------------------------------------
  logic local_src_r;
  logic remote_src_r;
  logic wake_r;
  logic wake_set;
  logic uv_rise;
  logic local_prev_r;
  logic remote_prev_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      local_src_r <= 1'b0;
    end else if (mode.local_wake_event && mode.in_low_power) begin
      local_src_r <= 1'b1;                                    // R24
    end else if (mode.enter_low_power) begin
      local_src_r <= 1'b0;                                    // R24
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      remote_src_r <= 1'b0;
    end else if (mode.remote_wake_event && low_ok) begin
      remote_src_r <= 1'b1;                                   // R24
    end else if (mode.enter_low_power) begin
      remote_src_r <= 1'b0;                                   // R24
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      local_prev_r  <= 1'b0;
      remote_prev_r <= 1'b0;
    end else begin
      local_prev_r  <= local_src_r;
      remote_prev_r <= remote_src_r;
    end
  end

  // wake sources count on their rising edge only
  assign wake_set = (local_src_r && !local_prev_r)
                 || (remote_src_r && !remote_prev_r)
                 || mode.wake_request || batt_recover;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_r <= 1'b0;
    end else if (wake_set) begin
      wake_r <= 1'b1;
    end else if (mode.enter_normal || mode.enter_low_power || uv_rise) begin
      wake_r <= 1'b0;                                         // R22
    end
  end

  // -----------------------------------------------------------------
  // power-on flag
  // -----------------------------------------------------------------
  // reset itself stands for the digital supply coming up
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_r.power_on <= 1'b1;                               // R23
    end else if (supply_rise) begin
      flags_r.power_on <= 1'b1;                               // R23
    end else if (mode.enter_normal) begin
      flags_r.power_on <= 1'b0;                               // R23
    end
  end

  // -----------------------------------------------------------------
  // temperature flags
  // -----------------------------------------------------------------
  // medium only records; nothing else reads it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_r.temp_medium <= 1'b0;
    end else if (normal_ok && pin_s.temp_above_medium) begin
      flags_r.temp_medium <= 1'b1;                            // R1 R3
    end else if (normal_ok || (low_ok && read_clear)) begin
      flags_r.temp_medium <= 1'b0;                            // R2
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_r.temp_high <= 1'b0;
    end else if (normal_ok && pin_s.temp_above_high) begin
      flags_r.temp_high <= 1'b1;                              // R4
    end else if (normal_ok && transmit_enable_low_fall) begin
      flags_r.temp_high <= 1'b0;                              // R5
    end
  end

  // -----------------------------------------------------------------
  // enable clamp detection
  // -----------------------------------------------------------------
  logic [CLW-1:0] clamp_cnt_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !tx_request) begin
      clamp_cnt_r <= '0;
    end else if (clamp_cnt_r <= CLW'(CLAMP_CYC)) begin
      clamp_cnt_r <= clamp_cnt_r + CLW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !tx_request) begin
      flags_r.clamped <= 1'b0;                                // R8
    end else if (clamp_cnt_r >= CLW'(CLAMP_CYC)) begin
      flags_r.clamped <= 1'b1;                                // R7
    end
  end

  // -----------------------------------------------------------------
  // bus error
  // -----------------------------------------------------------------
  // a level: no other logic acts on it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_r.bus_error <= 1'b0;
    end else if (!tx_request || tx_blocked) begin
      flags_r.bus_error <= 1'b0;                              // R10
    end else if (pin_s.rx_data != pin_s.txd) begin
      flags_r.bus_error <= !pin_s.valid_element;              // R9
    end else begin
      flags_r.bus_error <= 1'b0;                              // R10
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      transmitter_disable <= 1'b1;
    end else begin
      transmitter_disable <= tx_blocked || !tx_request;       // R6 R8
    end
  end

  // -----------------------------------------------------------------
  // undervoltage flags
  // -----------------------------------------------------------------
  logic core_set;
  logic core_clr;
  logic io_set;
  logic io_clr;
  logic wake_rise;

  assign wake_rise = wake_set && !wake_r;

  uv_filter #(
    .DET_CYC (CORE_DET_CYC),
    .REC_CYC (CORE_REC_CYC)
  ) u_core_uv (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .low_in    (pin_s.core_low),
    .set_pulse (core_set),
    .clr_pulse (core_clr)
  );

  // recovery of the interface supply is immediate
  uv_filter #(
    .DET_CYC (IO_DET_CYC),
    .REC_CYC (1)
  ) u_io_uv (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .low_in    (pin_s.iface_low),
    .set_pulse (io_set),
    .clr_pulse (io_clr)
  );

  assign uv_rise = batt_low_rise || core_set || io_set;

  // battery flag stays off after a wake even if still low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_r.batt_uv <= 1'b0;
    end else if (batt_low_rise) begin
      flags_r.batt_uv <= 1'b1;                                // R11
    end else if (!pin_s.batt_low || wake_rise) begin
      flags_r.batt_uv <= 1'b0;                                // R11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_r.core_uv <= 1'b0;
    end else if (core_set) begin
      flags_r.core_uv <= 1'b1;                                // R12
    end else if (core_clr || wake_rise) begin
      flags_r.core_uv <= 1'b0;                                // R12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_r.iface_uv <= 1'b0;
    end else if (io_set) begin
      flags_r.iface_uv <= 1'b1;                               // R13
    end else if (io_clr || !pin_s.iface_low || wake_rise) begin
      flags_r.iface_uv <= 1'b0;                               // R13
    end
  end

  // -----------------------------------------------------------------
  // sticky status bits
  // -----------------------------------------------------------------
  diag_pkg::flags_t flags_prev_r;
  logic [`STICKY_N-1:0] sticky_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_prev_r <= '0;
    end else begin
      flags_prev_r <= flags_r;
    end
  end

  // set beats a clear in the same cycle; S3 is not read-cleared
  generate
    for (gi = 0; gi < `STICKY_N; gi++) begin : g_sticky
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          sticky_r[gi] <= 1'b0;
        end else if (flags_r[gi] && !flags_prev_r[gi]) begin
          sticky_r[gi] <= 1'b1;                               // R21 R26
        end else if (read_clear && gi >= (`ST_ERR_LO - `ST_STICKY_LO)
                     && !flags_r[gi]) begin
          sticky_r[gi] <= 1'b0;                               // R17
        end
      end
    end
  endgenerate

  logic [`STATUS_W-1:0] status_nxt;

  always_comb begin
    status_nxt = '0;
    status_nxt[`ST_LOCAL_WAKE]  = local_src_r;                // R19
    status_nxt[`ST_REMOTE_WAKE] = remote_src_r;               // R19
    status_nxt[`ST_FIXED_SET]   = 1'b1;                       // R20
    status_nxt[`ST_ERR_HI:`ST_STICKY_LO] = sticky_r;          // R21
    status_nxt[`ST_SPARE_HI:`ST_SPARE_LO] = '0;               // R20
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_word <= '0;
      error_flag  <= 1'b0;
      flags       <= '0;
      wake_flag   <= 1'b0;
    end else begin
      status_word <= status_nxt;
      error_flag  <= |status_nxt[`ST_ERR_HI:`ST_ERR_LO];      // R14
      flags       <= flags_r;
      wake_flag   <= wake_r;
    end
  end

  // -----------------------------------------------------------------
  // serial readout
  // -----------------------------------------------------------------
  diag_pkg::readout_state_t rd_state_r;
  logic [IXW-1:0]           bit_idx_r;
  logic [IDW-1:0]           idle_cnt_r;
  logic                     read_enable;
  logic                     idle_hit;

  assign read_enable = pin_s.iface_is_5v ? !flags_r.iface_uv   // R16
                                         : !flags_r.core_uv;   // R16
  assign idle_hit    = idle_cnt_r >= IDW'(IDLE_CYC);
  assign read_clear  = (rd_state_r == diag_pkg::RD_SHIFT) && idle_hit;

  // any edge, rising or falling, restarts the quiet time
  always_ff @(posedge clk_sys) begin
    if (sys_rst || clk_any) begin
      idle_cnt_r <= '0;
    end else if (!idle_hit) begin
      idle_cnt_r <= idle_cnt_r + IDW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_state_r <= diag_pkg::RD_IDLE;
      bit_idx_r  <= '0;
    end else begin
      case (rd_state_r)
        diag_pkg::RD_IDLE: begin
          if (clk_rise && read_enable) begin
            rd_state_r <= diag_pkg::RD_SHIFT;                 // R15
            bit_idx_r  <= IXW'(1);                            // R25
          end
        end
        diag_pkg::RD_SHIFT: begin
          if (read_clear) begin
            rd_state_r <= diag_pkg::RD_IDLE;                  // R17
            bit_idx_r  <= '0;
          end else if (clk_rise && bit_idx_r < IXW'(`STATUS_W)) begin
            bit_idx_r <= bit_idx_r + IXW'(1);                 // R25
          end
        end
        default: begin
          rd_state_r <= diag_pkg::RD_IDLE;
          bit_idx_r  <= '0;
        end
      endcase
    end
  end

  // outside a readout the pin shows the summary error, active low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      error_out_low <= 1'b1;
    end else if (clk_rise && read_enable
                 && rd_state_r == diag_pkg::RD_IDLE) begin
      error_out_low <= !status_nxt[`ST_LOCAL_WAKE];           // R18 R25
    end else if (clk_rise && rd_state_r == diag_pkg::RD_SHIFT
                 && bit_idx_r < IXW'(`STATUS_W)) begin
      error_out_low <= !status_nxt[bit_idx_r];                // R18 R15
    end else if (rd_state_r == diag_pkg::RD_IDLE) begin
      error_out_low <= !(|status_nxt[`ST_ERR_HI:`ST_ERR_LO]); // R14
    end
  end

endmodule
`default_nettype wire

//--- sim/diag_status_monitor.sv
// Assertions on the diagnostic block's ports.
// Assumes one clock domain; bound to the block's top module.
`timescale 1ns/100ps
`default_nettype none
module diag_status_monitor #(
  parameter int unsigned CLAMP_CYC = 8,
  parameter int unsigned IDLE_CYC  = 50
) (
  input wire logic               clk_sys,
  input wire logic               sys_rst,
  input wire diag_pkg::pin_in_t  pins,
  input wire diag_pkg::mode_in_t mode,
  input wire logic               error_out_low,
  input wire logic               transmitter_disable,
  input wire logic               error_flag,
  input wire logic               wake_flag,
  input wire diag_pkg::flags_t   flags,
  input wire logic [12:0]        status_word
);
  logic        req;
  logic        sh_r;
  logic [7:0]  run_r;
  logic [15:0] idle_r;
  logic [2:0]  up_r;
  assign req = !pins.transmit_enable_low && pins.guardian_enable;
  // raw pin counts; the block adds its synchroniser delay on top
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !req) run_r <= 8'h00;
    else if (run_r != 8'hFF) run_r <= run_r + 8'h01;
  end
  always_ff @(posedge clk_sys) begin
    sh_r <= pins.shift_clk;
    if (sys_rst || pins.shift_clk != sh_r) idle_r <= 16'h0000;
    else if (idle_r != 16'hFFFF) idle_r <= idle_r + 16'h0001;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_released;
    !req [*5];
  endsequence
  sequence s_hold_off;
    (flags.temp_high || flags.clamped) [*2];
  endsequence
  sequence s_first_rise;
    !pins.shift_clk && idle_r > IDLE_CYC + 8 && pins.iface_is_5v
      && !flags.iface_uv ##1 pins.shift_clk;
  endsequence
  fixed_bits_a: assert property (up_r == 3'h7 |->
    status_word[2] && status_word[12:11] == 2'b00) else $error("fixed bits");
  error_or_a: assert property (1'b1 |-> ##[0:1]
    (error_flag == |status_word[10:4])) else $error("summary error");
  sticky_set_a: assert property (up_r == 3'h7 |->
    (status_word[10:3] & $past(flags, 2)) == $past(flags, 2))
    else $error("sticky bit missing");
  clamp_set_a: assert property (run_r == CLAMP_CYC + 6 |->
    flags.clamped) else $error("clamp late");
  clamp_early_a: assert property (run_r >= 5 && run_r < CLAMP_CYC |->
    !flags.clamped) else $error("clamp early");
  clamp_clear_a: assert property (s_released |-> !flags.clamped)
    else $error("clamp stuck");
  tx_off_a: assert property (s_hold_off |-> transmitter_disable)
    else $error("transmitter on");
  idle_out_a: assert property (idle_r > IDLE_CYC + 8 &&
    $stable(error_flag) |-> error_out_low == !error_flag)
    else $error("idle output");
  first_bit_a: assert property (s_first_rise |-> ##5
    error_out_low == !status_word[0]) else $error("first bit");
  wake_set_a: assert property (mode.wake_request |-> ##2 wake_flag)
    else $error("wake not set");
  wake_clear_a: assert property (!mode.wake_request &&
    (mode.enter_normal || mode.enter_low_power) |-> ##2 !wake_flag)
    else $error("wake not cleared");
endmodule
bind diag_flags_serial_status diag_status_monitor #(
  .CLAMP_CYC(CLAMP_CYC),
  .IDLE_CYC (IDLE_CYC)
) diag_status_monitor_i (.clk_sys, .sys_rst, .pins, .mode, .error_out_low,
  .transmitter_disable, .error_flag, .wake_flag, .flags, .status_word);
`default_nettype wire

//--- sim/host_reader.sv
// Host model that clocks the status word out serially.
// Assumes the block answers within four of its own clock cycles.
`timescale 1ns/100ps
`default_nettype none
module host_reader (
  input  wire logic  start,
  input  wire logic  slow,
  input  wire logic  error_out_low,
  output logic       shift_clk,
  output logic [12:0] word,
  output logic       done
);
  int half;
  initial begin
    shift_clk = 1'b0;
    word = 13'h0000;
    done = 1'b0;
  end
  // clock rests low between frames
  always @(posedge start) begin
    half = slow ? 160 : 80;
    #7;
    for (int i = 0; i < 13; i++) begin
      shift_clk = 1'b1;
      #(half);
      shift_clk = 1'b0;
      #(half - 10);
      word[i] = !error_out_low;
      #10;
    end
    done = 1'b1;
    wait (!start);
    done = 1'b0;
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the diagnostic flag and status block.
// Assumes host_reader and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned IDLE = 50;
  logic               clk_sys = 1'b0;
  logic               sys_rst = 1'b1;
  diag_pkg::pin_in_t  p;
  diag_pkg::pin_in_t  pins;
  diag_pkg::mode_in_t md;
  logic               start = 1'b0;
  logic               slow = 1'b0;
  logic               mism = 1'b0;
  logic               host_clk;
  logic               done;
  logic               err_low;
  logic [12:0]        word;
  logic [12:0]        e_now;
  logic [12:0]        exp_q[$];
  logic [31:0]        rnd = 32'h826C5B23;
  int                 err_count = 0;
  int                 total_checks = 0;
  always #10 clk_sys = ~clk_sys;
  always_comb begin
    pins = p;
    pins.shift_clk = host_clk;
  end
  diag_flags_serial_status #(.CLAMP_CYC(8), .CORE_DET_CYC(10),
    .CORE_REC_CYC(10), .IO_DET_CYC(10), .IDLE_CYC(IDLE))
  diag_flags_serial_status_i (.clk_sys, .sys_rst, .pins, .mode(md),
    .error_out_low(err_low), .transmitter_disable(), .error_flag(),
    .wake_flag(), .flags(), .status_word());
  host_reader host_reader_i (.start, .slow, .error_out_low(err_low),
    .shift_clk(host_clk), .word, .done);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys) begin
      rnd = lfsr(rnd);
      p.txd = rnd[0];
      p.rx_data = rnd[0] ^ mism;
      md[4:0] = 5'h00;
    end
  endtask
  task automatic xmit(input logic on, input logic v, input logic m,
                      input int n);
    p.transmit_enable_low = !on;
    p.guardian_enable = on;
    p.valid_element = v;
    mism = m;
    tick(n);
  endtask
  task automatic read_word(input logic [12:0] expv, input logic s);
    exp_q.push_back(expv);
    slow = s;
    start = 1'b1;
    for (int i = 0; i < 600 && done !== 1'b1; i++) tick(1);
    if (done !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t exp %h got %h", $time, expv, word);
    end
    start = 1'b0;
    tick(IDLE + 30);
  endtask
  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge done) begin
    e_now = exp_q.pop_front();
    total_checks++;
    if (word !== e_now) begin
      err_count++;
      $display("[FAIL] %0t exp %h got %h", $time, e_now, word);
    end
  end
  initial begin
    p = '0;
    p.batt_in_range = 1'b1;
    p.iface_is_5v = 1'b1;
    p.supply_ok = 1'b1;
    p.transmit_enable_low = 1'b1;
    md = '0;
    md.in_normal_power = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    tick(4);
    xmit(1'b1, 1'b1, 1'b1, 5);
    xmit(1'b0, 1'b0, 1'b0, 4);
    read_word(13'h00C, 1'b0);
    md.enter_normal = 1'b1;
    xmit(1'b1, 1'b0, 1'b1, 4);
    xmit(1'b0, 1'b0, 1'b0, 2);
    xmit(1'b1, 1'b0, 1'b0, 20);
    xmit(1'b0, 1'b0, 1'b0, 4);
    p.temp_above_medium = 1'b1;
    p.temp_above_high = 1'b1;
    tick(6);
    p.temp_above_medium = 1'b0;
    p.temp_above_high = 1'b0;
    p.batt_low = 1'b1;
    tick(6);
    p.batt_low = 1'b0;
    p.core_low = 1'b1;
    tick(20);
    p.core_low = 1'b0;
    p.iface_low = 1'b1;
    tick(20);
    p.iface_low = 1'b0;
    tick(20);
    read_word(13'h7FC, 1'b1);
    read_word(13'h02C, 1'b0);
    p.transmit_enable_low = 1'b0;
    tick(6);
    p.transmit_enable_low = 1'b1;
    read_word(13'h02C, 1'b0);
    md.wake_request = 1'b1;
    tick(4);
    p.iface_is_5v = 1'b0;
    md.in_normal_power = 1'b0;
    md.in_low_power = 1'b1;
    md.enter_low_power = 1'b1;
    tick(1);
    md.local_wake_event = 1'b1;
    md.remote_wake_event = 1'b1;
    tick(4);
    read_word(13'h00F, 1'b0);
    print_verdict();
  end
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
